// *** rtl/event_bank_pkg.sv ***
// Constants, register map and carrier types of the power event bank.
package event_bank_pkg;

    // Register offsets on the serial management port.
    localparam logic [7:0] ADDR_PT_LATCH = 8'h05;
    localparam logic [7:0] ADDR_PT_MASK = 8'h06;
    localparam logic [7:0] ADDR_PT_LIVE = 8'h07;
    localparam logic [7:0] ADDR_BUCK_LATCH = 8'h08;
    localparam logic [7:0] ADDR_BUCK_MASK = 8'h09;
    localparam logic [7:0] ADDR_BUCK_LIVE = 8'h0A;
    localparam logic [7:0] ADDR_BF_LATCH = 8'h0E;
    localparam logic [7:0] ADDR_BF_MASK = 8'h0F;
    localparam logic [7:0] ADDR_BF_LIVE = 8'h10;
    localparam logic [7:0] ADDR_LIN_LATCH = 8'h11;
    localparam logic [7:0] ADDR_LIN_MASK = 8'h12;
    localparam logic [7:0] ADDR_LIN_LIVE = 8'h13;

    // Field positions inside the boost and fuse registers and of the fuse supply bit in 0x07.
    localparam int BF_BOOST_BIT = 0;
    localparam int BF_FUSE_BIT = 7;
    localparam int PT_FUSE_SUPPLY_BIT = 7;

    // Source vector layout after synchronisation.
    localparam int NUM_SRC = 22;
    localparam int NUM_EV = 21;
    localparam int SRC_BUTTON = 0;
    localparam int SRC_LOW_INPUT = 1;
    localparam int SRC_THERM_LO = 2;
    localparam int SRC_THERM_HI = 5;
    localparam int SRC_BUCK_LO = 6;
    localparam int SRC_BUCK_HI = 12;
    localparam int SRC_BOOST = 13;
    localparam int SRC_LIN_LO = 14;
    localparam int SRC_LIN_HI = 19;
    localparam int SRC_FUSE_ERR = 20;
    localparam int SRC_FUSE_SUPPLY = 21;

    // Values after reset.
    localparam logic [5:0] PT_LATCH_RST = 6'h00;
    localparam logic [5:0] PT_MASK_RST = 6'h3F;
    localparam logic [6:0] BUCK_LATCH_RST = 7'h00;
    localparam logic [6:0] BUCK_MASK_RST = 7'h7F;
    localparam logic [1:0] BF_LATCH_RST = 2'h0;
    localparam logic [1:0] BF_MASK_RST = 2'h3;
    localparam logic [5:0] LIN_LATCH_RST = 6'h00;
    localparam logic [5:0] LIN_MASK_RST = 6'h3F;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // Debounce times in microseconds and their cycle counts at the system clock.
    localparam int CLK_MHZ = 40;
    localparam int DEB_SHORT_US = 3900;
    localparam int DEB_BUTTON_US = 31250;
    localparam int DEB_FAULT_US = 8000;
    localparam int DEB_SHORT_CYCLES = DEB_SHORT_US * CLK_MHZ;
    localparam int DEB_BUTTON_CYCLES = DEB_BUTTON_US * CLK_MHZ;
    localparam int DEB_FAULT_CYCLES = DEB_FAULT_US * CLK_MHZ;
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic fuse_supply;
        logic fuse_error;
        logic [5:0] linear;
        logic boost;
        logic [6:0] buck;
        logic [3:0] thermal;
        logic low_input;
        logic button;
    } detector_in_t;

    typedef struct packed {
        logic [NUM_SRC-1:0] sync1;
        logic [NUM_SRC-1:0] sync2;
        logic [5:0] pt_latch;
        logic [5:0] pt_mask;
        logic [6:0] buck_latch;
        logic [6:0] buck_mask;
        logic [1:0] bf_latch;
        logic [1:0] bf_mask;
        logic [5:0] lin_latch;
        logic [5:0] lin_mask;
        logic [7:0] rdata;
        logic irq_n;
    } bank_state_t;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic stable;
        logic rise;
        logic fall;
    } deb_state_t;

endpackage

// *** rtl/event_debouncer.sv ***
// One debounce channel: a level must hold for a full period before it is taken.
`timescale 1ns/1ps
`default_nettype none

module event_debouncer
    import event_bank_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_level,
    input wire logic [CNT_W-1:0] i_rise_cycles,
    input wire logic [CNT_W-1:0] i_fall_cycles,
    output logic o_stable,
    output logic o_rise,
    output logic o_fall
);

    deb_state_t st_reg;
    deb_state_t st_next;
    logic [CNT_W-1:0] period;

    always_comb begin
        st_next = st_reg;
        st_next.rise = 1'b0;
        st_next.fall = 1'b0;
        period = i_level ? i_rise_cycles : i_fall_cycles;
        // Any return to the stable level restarts the wait, so glitches never pass.
        if (i_level == st_reg.stable) begin
            st_next.count = CNT_ZERO;
        end else if (st_reg.count + CNT_ONE >= period) begin
            st_next.count = CNT_ZERO;
            st_next.stable = i_level;
            st_next.rise = i_level;
            st_next.fall = ~i_level;
        end else begin
            st_next.count = st_reg.count + CNT_ONE;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_stable = st_reg.stable;
    assign o_rise = st_reg.rise;
    assign o_fall = st_reg.fall;

endmodule

`default_nettype wire

// *** rtl/event_bank.sv ***
// Event latch, mask and live-state registers with the active-low interrupt output.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Register 0x05 latches button, low input, four thermal events; write one clears.
// - Register 0x06 masks those events bit for bit, all masked after reset.
// - Register 0x07 bit 0 follows button pin, bit 1 flags low input.
// - Bits 2 to 5 of 0x07 follow the four die temperature comparators.
// - Bit 7 of 0x07 shows whether the fuse program supply is present.
// - Register 0x08 latches seven buck overcurrent events; write one clears.
// - Register 0x09 masks the seven buck events, resetting to all ones.
// - Register 0x0A shows live buck overcurrent states, read only.
// - Register 0x0E latches boost overcurrent in bit 0, fuse error bit 7.
// - Register 0x0F masks boost in bit 0 and fuse error in bit 7.
// - Register 0x10 shows live boost overcurrent and fuse error states.
// - Register 0x11 latches six linear regulator overcurrent events; write one clears.
// - Register 0x12 masks the six linear regulator events, resetting to ones.
// - Register 0x13 shows live linear regulator overcurrent states.
// - Button falling edge debounce is lengthened by a two-bit selection.
// - Interrupt output is low while any latched unmasked event is pending.
// - A latched bit stays set until the host writes one to it.
// - Unmasking an already latched event drives the interrupt low at once.
// - An external event is latched only after a full stable debounce period.
module event_bank
    import event_bank_pkg::*;
#(
    parameter int SHORT_DEB_CYCLES = DEB_SHORT_CYCLES,
    parameter int BUTTON_DEB_CYCLES = DEB_BUTTON_CYCLES,
    parameter int FAULT_DEB_CYCLES = DEB_FAULT_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire reg_req_t i_reg_req,
    input wire detector_in_t i_detect,
    input wire logic [1:0] i_button_debounce_sel,
    output logic [7:0] o_reg_rdata,
    output logic o_irq_out_n
);

    bank_state_t st_reg;
    bank_state_t st_next;
    logic [NUM_SRC-1:0] raw;
    logic [NUM_SRC-1:0] lvl;
    logic [NUM_EV-1:0] deb_rise;
    logic [NUM_EV-1:0] deb_fall;
    logic [NUM_EV-1:0] ev;
    logic [CNT_W-1:0] short_per;
    logic [CNT_W-1:0] fault_per;
    logic [CNT_W-1:0] btn_rise_per;
    logic [CNT_W-1:0] btn_fall_per;
    logic [5:0] pt_clr;
    logic [6:0] buck_clr;
    logic [1:0] bf_clr;
    logic [5:0] lin_clr;
    logic [5:0] pt_live;
    logic [7:0] rd_mux;

    assign raw = {i_detect.fuse_supply, i_detect.fuse_error, i_detect.linear, i_detect.boost,
                  i_detect.buck, i_detect.thermal, i_detect.low_input, i_detect.button};
    assign lvl = st_reg.sync2;

    assign short_per = CNT_W'(SHORT_DEB_CYCLES);
    assign fault_per = CNT_W'(FAULT_DEB_CYCLES);
    assign btn_rise_per = CNT_W'(BUTTON_DEB_CYCLES);
    // The selection multiplies the base wait; the longest setting is four times the base.
    assign btn_fall_per = CNT_W'(BUTTON_DEB_CYCLES * (int'(i_button_debounce_sel) + 1));

    genvar g;
    generate
        for (g = 0; g < NUM_EV; g++) begin : g_deb
            logic [CNT_W-1:0] rise_per;
            logic [CNT_W-1:0] fall_per;
            if (g == SRC_BUTTON) begin : g_btn
                assign rise_per = btn_rise_per;
                assign fall_per = btn_fall_per;
            end else if (g <= SRC_THERM_HI) begin : g_short
                assign rise_per = short_per;
                assign fall_per = short_per;
            end else begin : g_fault
                assign rise_per = fault_per;
                assign fall_per = fault_per;
            end
            event_debouncer u_deb (
                .i_mclk(i_mclk),
                .i_rst_n(i_rst_n),
                .i_level(lvl[g]),
                .i_rise_cycles(rise_per),
                .i_fall_cycles(fall_per),
                .o_stable(),
                .o_rise(deb_rise[g]),
                .o_fall(deb_fall[g])
            );
        end
    endgenerate

    // Button fires on release to low, thermal on both crossings, the rest on assertion.
    always_comb begin
        ev = deb_rise;
        ev[SRC_BUTTON] = deb_fall[SRC_BUTTON];
        ev[SRC_THERM_HI:SRC_THERM_LO] = deb_rise[SRC_THERM_HI:SRC_THERM_LO]
                                      | deb_fall[SRC_THERM_HI:SRC_THERM_LO];
    end

    // Write-one-to-clear strobes; unused bit positions are simply not stored.
    always_comb begin
        pt_clr = '0;
        buck_clr = '0;
        bf_clr = '0;
        lin_clr = '0;
        if (i_reg_req.wr) begin
            if (i_reg_req.addr == ADDR_PT_LATCH) begin
                pt_clr = i_reg_req.wdata[5:0];
            end
            if (i_reg_req.addr == ADDR_BUCK_LATCH) begin
                buck_clr = i_reg_req.wdata[6:0];
            end
            if (i_reg_req.addr == ADDR_BF_LATCH) begin
                bf_clr = {i_reg_req.wdata[BF_FUSE_BIT], i_reg_req.wdata[BF_BOOST_BIT]};
            end
            if (i_reg_req.addr == ADDR_LIN_LATCH) begin
                lin_clr = i_reg_req.wdata[5:0];
            end
        end
    end

    assign pt_live = lvl[SRC_THERM_HI:SRC_BUTTON];

    always_comb begin
        rd_mux = 8'h00;
        unique case (i_reg_req.addr)
            ADDR_PT_LATCH: rd_mux = {2'h0, st_reg.pt_latch};
            ADDR_PT_MASK: rd_mux = {2'h0, st_reg.pt_mask};
            ADDR_PT_LIVE: rd_mux = {lvl[SRC_FUSE_SUPPLY], 1'b0, pt_live};
            ADDR_BUCK_LATCH: rd_mux = {1'b0, st_reg.buck_latch};
            ADDR_BUCK_MASK: rd_mux = {1'b0, st_reg.buck_mask};
            ADDR_BUCK_LIVE: rd_mux = {1'b0, lvl[SRC_BUCK_HI:SRC_BUCK_LO]};
            ADDR_BF_LATCH: rd_mux = {st_reg.bf_latch[1], 6'h00, st_reg.bf_latch[0]};
            ADDR_BF_MASK: rd_mux = {st_reg.bf_mask[1], 6'h00, st_reg.bf_mask[0]};
            ADDR_BF_LIVE: rd_mux = {lvl[SRC_FUSE_ERR], 6'h00, lvl[SRC_BOOST]};
            ADDR_LIN_LATCH: rd_mux = {2'h0, st_reg.lin_latch};
            ADDR_LIN_MASK: rd_mux = {2'h0, st_reg.lin_mask};
            ADDR_LIN_LIVE: rd_mux = {2'h0, lvl[SRC_LIN_HI:SRC_LIN_LO]};
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        // Detector outputs are analog and asynchronous to this clock.
        st_next.sync1 = raw;
        st_next.sync2 = st_reg.sync1;
        // The set term is applied after the clear, so a coincident event survives.
        st_next.pt_latch = (st_reg.pt_latch & ~pt_clr)
                         | ev[SRC_THERM_HI:SRC_BUTTON];
        st_next.buck_latch = (st_reg.buck_latch & ~buck_clr)
                           | ev[SRC_BUCK_HI:SRC_BUCK_LO];
        st_next.bf_latch = (st_reg.bf_latch & ~bf_clr)
                         | {ev[SRC_FUSE_ERR], ev[SRC_BOOST]};
        st_next.lin_latch = (st_reg.lin_latch & ~lin_clr)
                          | ev[SRC_LIN_HI:SRC_LIN_LO];
        if (i_reg_req.wr) begin
            if (i_reg_req.addr == ADDR_PT_MASK) begin
                st_next.pt_mask = i_reg_req.wdata[5:0];
            end
            if (i_reg_req.addr == ADDR_BUCK_MASK) begin
                st_next.buck_mask = i_reg_req.wdata[6:0];
            end
            if (i_reg_req.addr == ADDR_BF_MASK) begin
                st_next.bf_mask = {i_reg_req.wdata[BF_FUSE_BIT],
                                   i_reg_req.wdata[BF_BOOST_BIT]};
            end
            if (i_reg_req.addr == ADDR_LIN_MASK) begin
                st_next.lin_mask = i_reg_req.wdata[5:0];
            end
        end
        if (i_reg_req.rd) begin
            st_next.rdata = rd_mux;
        end
        // Built from the next values so the pin moves in the same edge as the registers.
        st_next.irq_n = ~(|(st_next.pt_latch & ~st_next.pt_mask)
                        | |(st_next.buck_latch & ~st_next.buck_mask)
                        | |(st_next.bf_latch & ~st_next.bf_mask)
                        | |(st_next.lin_latch & ~st_next.lin_mask));
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg.sync1 <= '0;
            st_reg.sync2 <= '0;
            st_reg.pt_latch <= PT_LATCH_RST;
            st_reg.pt_mask <= PT_MASK_RST;
            st_reg.buck_latch <= BUCK_LATCH_RST;
            st_reg.buck_mask <= BUCK_MASK_RST;
            st_reg.bf_latch <= BF_LATCH_RST;
            st_reg.bf_mask <= BF_MASK_RST;
            st_reg.lin_latch <= LIN_LATCH_RST;
            st_reg.lin_mask <= LIN_MASK_RST;
            st_reg.rdata <= RDATA_RST;
            st_reg.irq_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_reg_rdata = st_reg.rdata;
    assign o_irq_out_n = st_reg.irq_n;

    // Checks on the register behaviour and the interrupt pin.
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    logic any_pending;
    assign any_pending = |(st_reg.pt_latch & ~st_reg.pt_mask)
                       | |(st_reg.buck_latch & ~st_reg.buck_mask)
                       | |(st_reg.bf_latch & ~st_reg.bf_mask)
                       | |(st_reg.lin_latch & ~st_reg.lin_mask);

    a_irq_follows_pending: assert property (
        o_irq_out_n == !any_pending)
        else $error("interrupt pin disagrees with pending events");

    a_latch_sticky: assert property (
        ((st_reg.buck_latch & ~buck_clr) != 7'h00)
        |=> ((st_reg.buck_latch & $past(st_reg.buck_latch & ~buck_clr))
             == $past(st_reg.buck_latch & ~buck_clr)))
        else $error("latched buck bit dropped without a clear");

    a_set_beats_clear: assert property (
        ((ev[SRC_THERM_HI:SRC_BUTTON] & pt_clr) != 6'h00)
        |=> ((st_reg.pt_latch & $past(ev[SRC_THERM_HI:SRC_BUTTON])) != 6'h00))
        else $error("event lost against its clear");

    a_unmask_drives_irq: assert property (
        (i_reg_req.wr && i_reg_req.addr == ADDR_PT_MASK
         && ((st_reg.pt_latch & ~i_reg_req.wdata[5:0]) != 6'h00))
        |=> !o_irq_out_n)
        else $error("unmasking a latched event did not assert interrupt");

    a_unused_read_zero: assert property (
        (i_reg_req.rd && i_reg_req.addr == ADDR_BF_LATCH)
        |=> (o_reg_rdata[6:1] == 6'h00))
        else $error("unused bits of boost and fuse latch read nonzero");

    a_live_state_read: assert property (
        (i_reg_req.rd && i_reg_req.addr == ADDR_PT_LIVE)
        |=> (o_reg_rdata == {$past(lvl[SRC_FUSE_SUPPLY]), 1'b0, $past(pt_live)}))
        else $error("live state register read wrong value");

    a_buck_full_clear: assert property (
        (i_reg_req.wr && i_reg_req.addr == ADDR_BUCK_LATCH && i_reg_req.wdata == 8'hFF
         && ev[SRC_BUCK_HI:SRC_BUCK_LO] == 7'h00)
        |=> (st_reg.buck_latch == 7'h00))
        else $error("buck latch not cleared by write of ones");

    a_mask_write_lands: assert property (
        (i_reg_req.wr && i_reg_req.addr == ADDR_LIN_MASK)
        |=> (st_reg.lin_mask == $past(i_reg_req.wdata[5:0])))
        else $error("linear mask write did not land");

    // The pin may already be released when the pulse shows, so look at the window behind it.
    a_button_on_fall: assert property (
        ev[SRC_BUTTON] |-> ($past(!lvl[SRC_BUTTON]) && $past(!lvl[SRC_BUTTON], 2)))
        else $error("button event without a settled low level");

    a_pt_mask_write: assert property (
        (i_reg_req.wr && i_reg_req.addr == ADDR_PT_MASK)
        |=> (st_reg.pt_mask == $past(i_reg_req.wdata[5:0])))
        else $error("power and thermal mask write did not land");

    a_buck_mask_write: assert property (
        (i_reg_req.wr && i_reg_req.addr == ADDR_BUCK_MASK)
        |=> (st_reg.buck_mask == $past(i_reg_req.wdata[6:0])))
        else $error("buck mask write did not land");

    a_bf_mask_write: assert property (
        (i_reg_req.wr && i_reg_req.addr == ADDR_BF_MASK)
        |=> (st_reg.bf_mask == {$past(i_reg_req.wdata[BF_FUSE_BIT]),
                                $past(i_reg_req.wdata[BF_BOOST_BIT])}))
        else $error("boost and fuse mask write did not land");

    a_pt_full_clear: assert property (
        (i_reg_req.wr && i_reg_req.addr == ADDR_PT_LATCH && i_reg_req.wdata == 8'hFF
         && ev[SRC_THERM_HI:SRC_BUTTON] == 6'h00)
        |=> (st_reg.pt_latch == 6'h00))
        else $error("power and thermal latch not cleared by write of ones");

    a_bf_full_clear: assert property (
        (i_reg_req.wr && i_reg_req.addr == ADDR_BF_LATCH && i_reg_req.wdata == 8'hFF
         && !ev[SRC_FUSE_ERR] && !ev[SRC_BOOST])
        |=> (st_reg.bf_latch == 2'h0))
        else $error("boost and fuse latch not cleared by write of ones");

    a_lin_full_clear: assert property (
        (i_reg_req.wr && i_reg_req.addr == ADDR_LIN_LATCH && i_reg_req.wdata == 8'hFF
         && ev[SRC_LIN_HI:SRC_LIN_LO] == 6'h00)
        |=> (st_reg.lin_latch == 6'h00))
        else $error("linear latch not cleared by write of ones");

    a_buck_live_read: assert property (
        (i_reg_req.rd && i_reg_req.addr == ADDR_BUCK_LIVE)
        |=> (o_reg_rdata == {1'b0, $past(lvl[SRC_BUCK_HI:SRC_BUCK_LO])}))
        else $error("buck live state read wrong value");

    a_bf_live_read: assert property (
        (i_reg_req.rd && i_reg_req.addr == ADDR_BF_LIVE)
        |=> (o_reg_rdata == {$past(lvl[SRC_FUSE_ERR]), 6'h00, $past(lvl[SRC_BOOST])}))
        else $error("boost and fuse live state read wrong value");

    a_lin_live_read: assert property (
        (i_reg_req.rd && i_reg_req.addr == ADDR_LIN_LIVE)
        |=> (o_reg_rdata == {2'h0, $past(lvl[SRC_LIN_HI:SRC_LIN_LO])}))
        else $error("linear live state read wrong value");

    a_mask_unused_zero: assert property (
        (i_reg_req.rd && i_reg_req.addr == ADDR_BUCK_MASK)
        |=> !o_reg_rdata[7])
        else $error("unused buck mask bit read nonzero");

    a_unmapped_read_zero: assert property (
        (i_reg_req.rd && (i_reg_req.addr < ADDR_PT_LATCH || i_reg_req.addr > ADDR_LIN_LIVE
         || (i_reg_req.addr > ADDR_BUCK_LIVE && i_reg_req.addr < ADDR_BF_LATCH)))
        |=> (o_reg_rdata == 8'h00))
        else $error("unmapped address read nonzero");

    a_pt_set_cause: assert property (
        1'b1 |=> ((st_reg.pt_latch & ~$past(st_reg.pt_latch)
                   & ~$past(ev[SRC_THERM_HI:SRC_BUTTON])) == 6'h00))
        else $error("power and thermal latch bit set without an event");

    a_buck_set_cause: assert property (
        1'b1 |=> ((st_reg.buck_latch & ~$past(st_reg.buck_latch)
                   & ~$past(ev[SRC_BUCK_HI:SRC_BUCK_LO])) == 7'h00))
        else $error("buck latch bit set without an event");

    c_irq_raised: cover property (o_irq_out_n ##1 !o_irq_out_n);
    c_clear_releases: cover property (!o_irq_out_n && i_reg_req.wr ##1 o_irq_out_n);
    c_set_and_clear: cover property ((ev[SRC_THERM_HI:SRC_BUTTON] & pt_clr) != 6'h00);
    c_button_event: cover property (ev[SRC_BUTTON]);
    c_unmask_pending: cover property ((i_reg_req.wr && i_reg_req.addr == ADDR_BUCK_MASK) ##1 !o_irq_out_n);

endmodule

`default_nettype wire

// *** verif/host_model.sv ***
// Host processor model that issues single-byte register strobes to the event bank.
`timescale 1ns/1ps
`default_nettype none

module host_model
    import event_bank_pkg::*;
(
    input wire logic i_mclk,
    output var reg_req_t o_req
);
    initial o_req = '0;

    // Strobes move 2 ns after an edge so they are never in flux at a sampling edge.
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        #2;
        o_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge i_mclk);
        #2;
        o_req = '0;
    endtask
endmodule

`default_nettype wire

// *** verif/event_bank_tb.sv ***
// Self-checking bench for the event bank, driven through the host model.
`timescale 1ns/1ps
`default_nettype none

module event_bank_tb;
    import event_bank_pkg::*;
    localparam int FAULT_N = 12;
    localparam int BTN_N = 16;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    reg_req_t req;
    detector_in_t det = 22'h200001;
    logic [1:0] sel = 2'h0;
    logic [7:0] rdata;
    logic irq_n;
    logic rd_due = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] adr_q[$];
    int err_count = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'hCA1E;
    logic [7:0] map_a [14] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0E,
        8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h00, 8'h14};
    logic [7:0] map_r [14] = '{8'h00, 8'h3F, 8'h81, 8'h00, 8'h7F, 8'h00, 8'h00,
        8'h81, 8'h00, 8'h00, 8'h3F, 8'h00, 8'h00, 8'h00};
    logic [7:0] mk_a [4] = '{8'h06, 8'h09, 8'h0F, 8'h12};
    logic [7:0] mk_v [4] = '{8'h3F, 8'h7F, 8'h81, 8'h3F};
    logic [7:0] lt_a [4] = '{8'h05, 8'h08, 8'h0E, 8'h11};
    logic [7:0] lt_v [4] = '{8'h3E, 8'h7F, 8'h81, 8'h3F};

    event_bank #(
        .SHORT_DEB_CYCLES(8),
        .BUTTON_DEB_CYCLES(BTN_N),
        .FAULT_DEB_CYCLES(FAULT_N)
    ) DUT (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_reg_req(req),
        .i_detect(det),
        .i_button_debounce_sel(sel),
        .o_reg_rdata(rdata),
        .o_irq_out_n(irq_n)
    );

    host_model host (
        .i_mclk(i_mclk),
        .o_req(req)
    );

    initial begin
        forever #12.5 i_mclk = ~i_mclk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        adr_q.push_back(a);
        host.access(1'b0, a, 8'h00);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d);
    endtask

    task automatic irq_is(input logic e);
        check("irq", {7'h00, irq_n}, {7'h00, e});
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask

    // A missing interrupt must end the run rather than hang it.
    task automatic wait_irq(input logic e, input int lim);
        int n;
        n = 0;
        while (irq_n !== e && n < lim) begin
            cycles(1);
            n++;
        end
        irq_is(e);
        if (irq_n !== e) begin
            complete_run();
        end
    endtask

    // Read data stands one cycle after the edge that took the strobe.
    always @(posedge i_mclk) begin
        if (rd_due) begin
            check($sformatf("rdata at %h", adr_q.pop_front()), rdata, exp_q.pop_front());
        end
        rd_due <= req.rd;
    end

    initial begin
        repeat (3) @(posedge i_mclk);
        #2;
        i_rst_n = 1'b1;
        for (int i = 0; i < 14; i++) begin
            rd(map_a[i], map_r[i]);
        end
        $display("test reset values done");

        for (int i = 0; i < 4; i++) begin
            seed = xorshift(seed);
            wr(mk_a[i], seed[7:0]);
            rd(mk_a[i], seed[7:0] & mk_v[i]);
            wr(mk_a[i], 8'hFF);
            rd(mk_a[i], mk_v[i]);
        end
        wr(8'h07, 8'h00);
        rd(8'h07, 8'h81);
        det.fuse_supply = 1'b0;
        cycles(4);
        rd(8'h07, 8'h01);
        det.fuse_supply = 1'b1;
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'h00);
        wr(8'h14, 8'hFF);
        rd(8'h14, 8'h00);
        $display("test mask access done");

        det = 22'h3FFFFF;
        cycles(FAULT_N + 12);
        rd(8'h07, 8'hBF);
        rd(8'h0A, 8'h7F);
        rd(8'h10, 8'h81);
        rd(8'h13, 8'h3F);
        irq_is(1'b1);
        det = 22'h200001;
        cycles(FAULT_N + 12);
        for (int i = 0; i < 4; i++) begin
            rd(lt_a[i], lt_v[i]);
        end
        rd(8'h07, 8'h81);
        wr(8'h09, 8'h7C);
        irq_is(1'b0);
        wr(8'h08, 8'h01);
        irq_is(1'b0);
        wr(8'h08, 8'h02);
        irq_is(1'b1);
        rd(8'h08, 8'h7C);
        wr(8'h09, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            wr(lt_a[i], 8'hFF);
            rd(lt_a[i], 8'h00);
        end
        // Thermal crossings latch in both directions, so a fall alone must set the bits again.
        det.thermal = 4'hF;
        cycles(FAULT_N + 12);
        wr(8'h05, 8'h3C);
        det.thermal = 4'h0;
        cycles(FAULT_N + 12);
        rd(8'h05, 8'h3C);
        wr(8'h05, 8'h3C);
        $display("test fault events done");

        // A low pulse a little shorter than the selected period must be ignored.
        wr(8'h06, 8'h3E);
        for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            det.button = 1'b0;
            cycles(BTN_N * (s + 1) - 6);
            det.button = 1'b1;
            cycles(30);
            irq_is(1'b1);
            det.button = 1'b0;
            wait_irq(1'b0, BTN_N * (s + 1) + 20);
            det.button = 1'b1;
            cycles(30);
            rd(8'h05, 8'h01);
            wr(8'h05, 8'h01);
            irq_is(1'b1);
        end
        $display("test button debounce done");
        cycles(4);
        complete_run();
    end
endmodule

`default_nettype wire
